// File: rtl/ddr_b2_host.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module ddr_b2_host
  import ddr_b2_pkg::*;
#(
  parameter int DQ_W = DQ_W_WIDE,
  parameter int ADDR_W = ADDR_W_WIDE
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [2*DQ_W-1:0] req_wdata,
  output logic rsp_valid,
  input wire logic rsp_ready,
  output logic [2*DQ_W-1:0] rsp_data,
  ddr_b2_link_if.host_end link
);
  localparam logic CFG_EXP = (DQ_W == DQ_W_NARROW) ? CFG_NARROW : CFG_WIDE;

  // Organization and clock rate checks
  if (!(DQ_W == DQ_W_WIDE || DQ_W == DQ_W_NARROW)) begin : g_chk_w
    $error("DQ_W must be 36 or 18"); // RULE12
  end
  if (CORE_MHZ / CORE_PER_CK > GRADE_MAX_MHZ_500) begin : g_chk_f
    $error("Master clock above grade ceiling"); // RULE11
  end

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    ck_phase_t phase; // Quarter of master clock
    logic ck; // Master clock out
    logic wclk; // Write data clock out
    logic ld_n; // Load strobe out
    logic rw; // Read/write out
    logic [ADDR_W-1:0] addr; // Address out
    logic [DQ_W-1:0] dq_o; // Data drive value
    logic dq_oe; // Data drive enable
    logic wr_active; // Write beats on the bus
    logic [DQ_W-1:0] wbeat1; // Upper half waiting
    logic pend; // Request held
    logic pend_write;
    logic [ADDR_W-1:0] pend_addr;
    logic [2*DQ_W-1:0] pend_data;
    logic [4:0] rd_hist; // Reads sampled at recent rises
    logic [1:0] inflight; // Reads not yet buffered
    logic [DQ_W-1:0] sync1; // Bus synchroniser stage one
    logic [DQ_W-1:0] sync2; // Bus synchroniser stage two
    logic [DQ_W-1:0] rbeat0; // First read beat
    logic push; // Response word ready
    logic [2*DQ_W-1:0] push_data;
    logic req_ready;
    logic cfg_strap;
    logic separate_io_mode_strap_strap;
  } host_state_t;

  host_state_t r;
  host_state_t n;
  logic fifo_in_ready;
  logic [1:0] fifo_level;
  logic read_ok;
  logic write_ok;

  // Room for one more read, counting words still on the way
  function automatic logic credit_ok(input logic [1:0] a, input logic [1:0] b);
    return (3'(a) + 3'(b)) < 3'(RSP_DEPTH);
  endfunction

  assign read_ok = fifo_in_ready && credit_ok(r.inflight, fifo_level);
  // Turnaround: no write whose beats meet returning read data
  assign write_ok = !(r.rd_hist[2] || r.rd_hist[3]); // RULE9

  ////////////////////////////////////////////////////////////////////////////
  // Next state: divider, command issue, read return
  always_comb begin
    n = r;
    if (clk_en) begin
      // Push lasts one cycle; frozen with the rest
      n.push = 1'b0;
      n.sync1 = link.dq_bus;
      n.sync2 = r.sync1;
      if (req_valid && r.req_ready) begin
        n.pend = 1'b1;
        n.pend_write = req_write;
        n.pend_addr = req_addr;
        n.pend_data = req_wdata;
      end
      case (r.phase)
        PH_LOW: begin
          // Master clock rises; note what the device samples
          n.phase = PH_RISE;
          n.ck = 1'b1;
          n.wclk = 1'b1;
          n.rd_hist = {r.rd_hist[3:0], (r.ld_n == LD_ACTIVE) && (r.rw == RW_READ)};
        end
        PH_RISE: begin
          n.phase = PH_HIGH;
          if (r.wr_active) begin
            n.dq_o = r.wbeat1; // RULE15
          end
        end
        PH_HIGH: begin
          n.phase = PH_FALL;
          n.ck = 1'b0;
          n.wclk = 1'b0;
        end
        PH_FALL: begin
          // A quarter cycle ahead of the rise: present the next operation
          n.phase = PH_LOW;
          n.ld_n = ~LD_ACTIVE;
          n.dq_oe = 1'b0;
          n.wr_active = 1'b0;
          if (r.pend && ((r.pend_write && write_ok) || (!r.pend_write && read_ok))) begin
            n.ld_n = LD_ACTIVE; // RULE7
            n.addr = r.pend_addr; // RULE10
            n.pend = 1'b0;
            if (r.pend_write) begin
              n.rw = RW_WRITE;
              n.dq_o = r.pend_data[DQ_W-1:0]; // RULE15
              n.dq_oe = 1'b1;
              n.wbeat1 = r.pend_data[2*DQ_W-1:DQ_W]; // RULE8
              n.wr_active = 1'b1;
            end else begin
              n.rw = RW_READ;
              n.inflight = r.inflight + 2'd1;
            end
          end
        end
        default: begin
          n.phase = PH_LOW;
        end
      endcase
      // First beat seen two stages after the third rise
      if (r.phase == PH_FALL && r.rd_hist[3]) begin
        n.rbeat0 = r.sync2; // RULE6
      end
      // Second beat completes the word
      if (r.phase == PH_RISE && r.rd_hist[4]) begin
        n.push = 1'b1; // RULE8
        n.push_data = {r.sync2, r.rbeat0};
        n.inflight = r.inflight - 2'd1;
      end
      n.req_ready = !n.pend;
    end
  end

  // State register; straps held from reset onward
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.phase <= PH_LOW;
      r.ld_n <= ~LD_ACTIVE;
      r.cfg_strap <= CFG_EXP; // RULE13
      r.separate_io_mode_strap_strap <= SEPARATE_IO_MODE_STRAP_COMMON; // RULE14
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read words wait here until the user takes them
  ddr_pair_fifo #(
    .WIDTH(2 * DQ_W),
    .DEPTH(RSP_DEPTH)
  ) u_rsp_fifo (
    .clk(core_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .in_valid(r.push),
    .in_ready(fifo_in_ready),
    .in_data(r.push_data),
    .out_valid(rsp_valid),
    .out_ready(rsp_ready),
    .out_data(rsp_data),
    .level(fifo_level)
  );

  assign req_ready = r.req_ready;
  assign link.ck = r.ck;
  assign link.write_data_clock = r.wclk;
  assign link.load_strobe_n = r.ld_n;
  assign link.read_not_write = r.rw;
  assign link.sync_address_bus = r.addr;
  assign link.dq_host_o = r.dq_o;
  assign link.dq_host_oe = r.dq_oe;
  assign link.width_cfg_strap = r.cfg_strap;
  assign link.separate_io_mode_strap = r.separate_io_mode_strap_strap;
endmodule
`default_nettype wire

// File: common/ddr_b2_pkg.sv
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
package ddr_b2_pkg;
  // Data bus organizations
  localparam int DQ_W_WIDE = 36;
  localparam int DQ_W_NARROW = 18;
  // Word address bits at the wide organization (two-beat words)
  localparam int ADDR_W_WIDE = 22;
  // Beats per access and read latency in master clock cycles
  localparam int BURST_BEATS = 2;
  localparam int READ_LATENCY = 3;
  // Core clock rate and divider that builds the master clock
  localparam int CORE_MHZ = 40;
  localparam int CORE_PER_CK = 4;
  // Grade ceilings on the master clock, slowest grade binds
  localparam int GRADE_MAX_MHZ_675 = 675;
  localparam int GRADE_MAX_MHZ_625 = 625;
  localparam int GRADE_MAX_MHZ_550 = 550;
  localparam int GRADE_MAX_MHZ_500 = 500;
  // Response buffer depth
  localparam int RSP_DEPTH = 2;
  // Pin encodings
  localparam logic LD_ACTIVE = 1'b0;
  localparam logic RW_READ = 1'b1;
  localparam logic RW_WRITE = 1'b0;
  localparam logic CFG_WIDE = 1'b0;
  localparam logic CFG_NARROW = 1'b1;
  localparam logic SEPARATE_IO_MODE_STRAP_COMMON = 1'b0;
  // Quarter phases of the master clock, Gray ordered
  typedef enum logic [1:0] {
    PH_RISE = 2'b00,
    PH_HIGH = 2'b01,
    PH_FALL = 2'b11,
    PH_LOW = 2'b10
  } ck_phase_t;
endpackage
`default_nettype wire

// File: common/ddr_b2_link_if.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
interface ddr_b2_link_if
  import ddr_b2_pkg::*;
#(
  parameter int DQ_W = DQ_W_WIDE,
  parameter int ADDR_W = ADDR_W_WIDE
);
  logic ck; // Master clock
  logic write_data_clock; // Write data capture clock
  logic load_strobe_n; // Operation request, active low
  logic read_not_write; // High for read
  logic [ADDR_W-1:0] sync_address_bus; // Word address
  logic [DQ_W-1:0] dq_host_o; // Host drive value
  logic dq_host_oe; // Host drives the data bus
  logic [DQ_W-1:0] dq_dev_o; // Device drive value
  logic dq_dev_oe; // Device drives the data bus
  logic [DQ_W-1:0] dq_bus; // Resolved shared bus
  logic width_cfg_strap; // Low selects wide organization
  logic separate_io_mode_strap; // Low selects common data bus

  // Shared bus level; device wins while it drives
  assign dq_bus = dq_dev_oe ? dq_dev_o : dq_host_o;

  modport host_end (
    output ck, write_data_clock, load_strobe_n, read_not_write, sync_address_bus,
    output dq_host_o, dq_host_oe, width_cfg_strap, separate_io_mode_strap,
    input dq_bus
  );
  modport device_end (
    input ck, write_data_clock, load_strobe_n, read_not_write, sync_address_bus,
    input dq_bus, width_cfg_strap, separate_io_mode_strap,
    output dq_dev_o, dq_dev_oe
  );
endinterface
`default_nettype wire

// File: rtl/ddr_pair_fifo.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module ddr_pair_fifo #(
  parameter int WIDTH = 72,
  parameter int DEPTH = 2,
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1,
  localparam int LW = $clog2(DEPTH + 1)
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [LW-1:0] level
);
  // Pointer wrap logic needs a power of two
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("DEPTH must be a power of two, at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem; // Entries
    logic [PW-1:0] wr_ptr; // Next slot to fill
    logic [PW-1:0] rd_ptr; // Oldest slot
    logic [LW-1:0] count; // Occupancy
  } fifo_state_t;

  fifo_state_t state_reg;
  fifo_state_t state_next;
  logic push;
  logic pop;

  // Full and empty straight from the occupancy count
  assign in_ready = (state_reg.count != LW'(DEPTH));
  assign out_valid = (state_reg.count != '0);
  assign out_data = state_reg.mem[state_reg.rd_ptr];
  assign level = state_reg.count;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Next state
  always_comb begin
    state_next = state_reg;
    if (clk_en) begin
      if (push) begin
        state_next.mem[state_reg.wr_ptr] = in_data;
        state_next.wr_ptr = state_reg.wr_ptr + 1'b1;
      end
      if (pop) begin
        state_next.rd_ptr = state_reg.rd_ptr + 1'b1;
      end
      // Simultaneous push and pop keep the count
      if (push && !pop) begin
        state_next.count = state_reg.count + 1'b1;
      end else if (pop && !push) begin
        state_next.count = state_reg.count - 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end
endmodule
`default_nettype wire

// File: rtl/ddr_b2_device.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// RULE1: Master clock samples commands, times all outputs
// RULE2: Write data clock only captures write data
// RULE3: Both write beats committed as one word
// RULE4: Read word split onto bus in turn
// RULE5: Address selects two-beat words, one bit fewer
// RULE6: Read data starts three cycles after command
// RULE7: One read or write per master cycle
// RULE8: Exactly two beats per address
// RULE9: Reads and writes share one data bus
// RULE10: Full address on own pins, single rate
// RULE11: Master clock within speed grade ceiling
// RULE12: Data bus 36 or 18 bits wide
// RULE13: Width strap low wide, high narrow
// RULE14: Separate-I/O strap held low
// RULE15: Low half on rise, high half on fall
module ddr_b2_device
  import ddr_b2_pkg::*;
#(
  parameter int DQ_W = DQ_W_WIDE,
  parameter int ADDR_W = ADDR_W_WIDE
) (
  input wire logic rst_n,
  input wire logic clk_en,
  ddr_b2_link_if.device_end link,
  output logic commit_valid,
  output logic [ADDR_W-1:0] commit_addr,
  output logic cfg_error
);
  // Word count: half the beat depth of the organization
  localparam int WORDS = 2 ** ADDR_W; // RULE5
  localparam int WORD_W = BURST_BEATS * DQ_W; // RULE3
  // Width strap level this build expects
  localparam logic CFG_EXP = (DQ_W == DQ_W_NARROW) ? CFG_NARROW : CFG_WIDE;

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks
  if (!(DQ_W == DQ_W_WIDE || DQ_W == DQ_W_NARROW)) begin : g_chk_w
    $error("DQ_W must be 36 or 18"); // RULE12
  end
  if ($bits(link.dq_bus) != DQ_W) begin : g_chk_dq
    $error("Link data width differs from DQ_W");
  end
  if ($bits(link.sync_address_bus) != ADDR_W) begin : g_chk_a
    $error("Link address width differs from ADDR_W");
  end
  if (ADDR_W < 1 || ADDR_W > 24) begin : g_chk_aw
    $error("ADDR_W out of range");
  end
  // Pair capture and mux serve two beats
  if (BURST_BEATS != 2) begin : g_chk_b
    $error("Two-beat bursts only");
  end
  // Read pipeline has three fixed stages
  if (READ_LATENCY != 3) begin : g_chk_l
    $error("Read pipeline fixed at three");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Master clock domain state
  typedef struct packed {
    logic wr_pend; // Write sampled, beats due
    logic [ADDR_W-1:0] wr_addr; // Its word address
    logic [2:0] rd_pipe; // Read sampled one to three rises ago
    logic [ADDR_W-1:0] rd_addr; // Latest read address
    logic [WORD_W-1:0] rd_word; // Array output, one rise after
    logic [WORD_W-1:0] rd_hold; // Second stage
    logic [WORD_W-1:0] out_word; // Word on the output mux
    logic dq_oe; // Device drives the bus
    logic commit_valid; // Array written at last rise
    logic [ADDR_W-1:0] commit_addr;
    logic [1:0] cfg_sync; // Width strap synchroniser
    logic [1:0] separate_io_mode_strap_sync; // Mode strap synchroniser
    logic cfg_error; // Straps disagree with build
  } dev_state_t;

  dev_state_t r;
  dev_state_t n;

  // Storage array, one double-width word per address
  // Two bus beats per entry, never split
  logic [WORD_W-1:0] array_mem [WORDS];

  // Write capture, write data clock domain
  logic [DQ_W-1:0] beat0_cap; // First beat, rising edge
  logic [WORD_W-1:0] pair_cap; // Both beats, set at falling edge

  logic cmd_valid;
  logic cmd_read;
  logic [WORD_W-1:0] array_rd;

  ////////////////////////////////////////////////////////////////////////////
  // Write data capture
  // Beat one lands at the rise; the fall joins it with beat two into one
  // word that stays put for a whole cycle, so the master clock can pick it
  // up at its next rise without racing the next rising capture.
  always_ff @(posedge link.write_data_clock or negedge rst_n) begin
    if (!rst_n) begin
      beat0_cap <= '0;
    end else if (clk_en) begin
      beat0_cap <= link.dq_bus; // RULE2
    end
  end

  // Falling edge completes the pair, low half first
  // Held a full cycle until the next fall
  always_ff @(negedge link.write_data_clock or negedge rst_n) begin
    if (!rst_n) begin
      pair_cap <= '0;
    end else if (clk_en) begin
      pair_cap <= {link.dq_bus, beat0_cap}; // RULE15
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command decode at the master clock
  // Address and control come only through this path; the write data
  // clock never sees them.
  // Both decode at the same rise as the address.
  assign cmd_valid = (link.load_strobe_n == LD_ACTIVE); // RULE7
  assign cmd_read = (link.read_not_write == RW_READ);

  // Array read port, addressed by the last sampled read
  assign array_rd = array_mem[r.rd_addr];

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    n = r;
    if (clk_en) begin
      // New operation: only one per rise, read or write
      n.wr_pend = cmd_valid && !cmd_read; // RULE1
      if (cmd_valid && !cmd_read) begin
        n.wr_addr = link.sync_address_bus; // RULE10
      end
      // Bit k: read sampled k rises before the last
      n.rd_pipe = {r.rd_pipe[1:0], cmd_valid && cmd_read}; // RULE1
      if (cmd_valid && cmd_read) begin
        n.rd_addr = link.sync_address_bus; // RULE10
      end
      // Write commit one rise after its command
      // One-cycle pulse per write, held high by back-to-back writes; address holds until next
      n.commit_valid = r.wr_pend; // RULE3
      if (r.wr_pend) begin
        n.commit_addr = r.wr_addr;
      end
      // Read pipeline: array, hold, then onto the output mux
      // Stages move only for their read; idle keeps the word
      if (r.rd_pipe[0]) begin
        n.rd_word = array_rd; // RULE4
      end
      if (r.rd_pipe[1]) begin
        n.rd_hold = r.rd_word;
      end
      if (r.rd_pipe[2]) begin
        n.out_word = r.rd_hold; // RULE6
      end
      // Drive for exactly one master cycle, two beats
      // Back-to-back reads keep the drive up
      n.dq_oe = r.rd_pipe[2]; // RULE8
      // Straps are pins from the far end
      n.cfg_sync = {r.cfg_sync[0], link.width_cfg_strap};
      n.separate_io_mode_strap_sync = {r.separate_io_mode_strap_sync[0], link.separate_io_mode_strap};
      // Flag a wrong organization or a separate-I/O setting
      // Only reported; the port keeps serving
      n.cfg_error = (r.cfg_sync[1] != CFG_EXP) || (r.separate_io_mode_strap_sync[1] != SEPARATE_IO_MODE_STRAP_COMMON); // RULE13
    end
  end

  // State register, master clock
  // Straps reset to the build value: no false error
  always_ff @(posedge link.ck or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.cfg_sync <= {2{CFG_EXP}};
      r.separate_io_mode_strap_sync <= {2{SEPARATE_IO_MODE_STRAP_COMMON}};
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Array write: both beats go in together, never a half word
  // No reset: contents are undefined until written, as in the part.
  // The fall before this rise joined both beats.
  always_ff @(posedge link.ck) begin
    if (clk_en && r.wr_pend) begin
      array_mem[r.wr_addr] <= pair_cap; // RULE3
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output multiplexer
  // The master clock level picks the half: low half while high after the
  // rise, high half after the fall. A mux on the clock is the cheapest
  // double-rate driver; the limit is that the halves only stay clean if the
  // clock duty cycle is near even.
  assign link.dq_dev_o = link.ck ? r.out_word[DQ_W-1:0] : r.out_word[WORD_W-1:DQ_W]; // RULE4
  // Enable is registered: turnaround on a rise
  assign link.dq_dev_oe = r.dq_oe; // RULE9

  assign commit_valid = r.commit_valid;
  assign commit_addr = r.commit_addr;
  assign cfg_error = r.cfg_error; // RULE14
endmodule
`default_nettype wire

// File: dv/ddr_b2_link_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module ddr_b2_link_asserts
  import ddr_b2_pkg::*;
#(
  parameter int DQ_W = DQ_W_WIDE,
  parameter int ADDR_W = ADDR_W_WIDE
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ck,
  input wire logic write_data_clock,
  input wire logic load_strobe_n,
  input wire logic read_not_write,
  input wire logic [ADDR_W-1:0] sync_address_bus,
  input wire logic dq_host_oe,
  input wire logic dq_dev_oe,
  input wire logic width_cfg_strap,
  input wire logic separate_io_mode_strap,
  input wire logic commit_valid
);
  // Decoded operations seen at a master clock rise
  logic rd_cmd;
  logic wr_cmd;
  assign rd_cmd = !load_strobe_n && (read_not_write == RW_READ);
  assign wr_cmd = !load_strobe_n && (read_not_write == RW_WRITE);
  // One master cycle of device drive, in core cycles
  sequence dev_burst;
    dq_dev_oe [*4];
  endsequence
  a_read_latency: assert property (@(posedge ck) disable iff (!rst_n)
    rd_cmd |-> ##4 dq_dev_oe) else $error("read data missing after latency");
  a_no_stray_read: assert property (@(posedge ck) disable iff (!rst_n)
    !rd_cmd |-> ##4 !dq_dev_oe) else $error("device drove bus without a read");
  a_write_commit: assert property (@(posedge ck) disable iff (!rst_n)
    wr_cmd |-> ##2 commit_valid) else $error("write not committed");
  a_no_stray_commit: assert property (@(posedge ck) disable iff (!rst_n)
    !wr_cmd |-> ##2 !commit_valid) else $error("commit without a write");
  a_dev_burst_len: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(dq_dev_oe) |-> dev_burst) else $error("read drive not one master cycle");
  a_ck_period: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(ck) |-> ##4 $rose(ck)) else $error("master clock period wrong");
  a_wclk_follows: assert property (@(posedge core_clk) disable iff (!rst_n)
    write_data_clock == ck) else $error("write clock differs from master clock");
  a_bus_single: assert property (@(posedge core_clk) disable iff (!rst_n)
    !(dq_host_oe && dq_dev_oe)) else $error("both ends drive the data bus");
  a_cmd_sdr: assert property (@(posedge core_clk) disable iff (!rst_n)
    ($changed(sync_address_bus) || $changed(load_strobe_n)) |-> (!ck && !$past(ck)))
    else $error("command changed inside a master cycle");
  a_strap_build: assert property (@(posedge core_clk) disable iff (!rst_n)
    separate_io_mode_strap == SEPARATE_IO_MODE_STRAP_COMMON &&
    width_cfg_strap == ((DQ_W == DQ_W_WIDE) ? CFG_WIDE : CFG_NARROW))
    else $error("straps differ from build");
endmodule
`default_nettype wire

// File: dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ddr_b2_pkg::*;
  localparam int AW = 6;
  localparam int DW = DQ_W_WIDE;
  localparam int W = 2 * DW;
  ////////////////////////////////////////////////////////////////////////////
  // Clocks, user side and scoreboard state
  logic core_clk = 1'h0;
  logic ck2 = 1'h0; // Bench master clock for the faulty pair
  logic rst_n = 1'h0;
  logic req_valid = 1'h0;
  logic req_ready;
  logic req_write = 1'h0;
  logic [AW-1:0] req_addr = 6'h00;
  logic [W-1:0] req_wdata = '0;
  logic rsp_valid;
  logic rsp_ready = 1'h0;
  logic [W-1:0] rsp_data;
  logic commit_valid;
  logic [AW-1:0] commit_addr;
  logic [AW-1:0] cq [$]; // Write addresses awaiting commit
  logic cfg_error;
  logic cfg_error_bad;
  logic stall = 1'h0; // Forces the receiver to stall
  logic hi_due = 1'h0; // Second write beat pending
  logic [31:0] rs = 32'h25;
  logic [31:0] r;
  logic [W-1:0] mem [int]; // Reference array
  logic [W-1:0] exp_q [$]; // Expected read words, in order
  logic [W-1:0] wq [$]; // Write words awaiting the wire
  int fails = 0;
  int checks_done = 0;
  always #12.5 core_clk = ~core_clk;
  // Unrelated phase to the core clock
  always #24 ck2 = ~ck2;
  ////////////////////////////////////////////////////////////////////////////
  // Both ends across one link, plus a faulty strap pair
  ddr_b2_link_if #(.DQ_W(DW), .ADDR_W(AW)) lnk ();
  ddr_b2_link_if #(.DQ_W(DW), .ADDR_W(AW)) lnk_bad ();
  ddr_b2_host #(.DQ_W(DW), .ADDR_W(AW)) u_ddr_b2_host (
    .core_clk(core_clk), .rst_n(rst_n), .clk_en(1'h1), .req_valid(req_valid),
    .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
    .rsp_data(rsp_data), .link(lnk));
  ddr_b2_device #(.DQ_W(DW), .ADDR_W(AW)) u_ddr_b2_device (
    .rst_n(rst_n), .clk_en(1'h1), .link(lnk), .commit_valid(commit_valid),
    .commit_addr(commit_addr), .cfg_error(cfg_error));
  ddr_b2_device #(.DQ_W(DW), .ADDR_W(AW)) u_ddr_b2_device_bad (
    .rst_n(rst_n), .clk_en(1'h1), .link(lnk_bad), .commit_valid(),
    .commit_addr(), .cfg_error(cfg_error_bad));
  ddr_b2_link_asserts #(.DQ_W(DW), .ADDR_W(AW)) u_ddr_b2_link_asserts (
    .core_clk(core_clk), .rst_n(rst_n), .ck(lnk.ck),
    .write_data_clock(lnk.write_data_clock), .load_strobe_n(lnk.load_strobe_n),
    .read_not_write(lnk.read_not_write), .sync_address_bus(lnk.sync_address_bus),
    .dq_host_oe(lnk.dq_host_oe), .dq_dev_oe(lnk.dq_dev_oe),
    .width_cfg_strap(lnk.width_cfg_strap),
    .separate_io_mode_strap(lnk.separate_io_mode_strap), .commit_valid(commit_valid));
  // Faulty host: idle bus, separate-I/O strap wrongly high
  assign lnk_bad.ck = ck2;
  assign lnk_bad.write_data_clock = ck2;
  initial begin
    lnk_bad.load_strobe_n = 1'h1;
    lnk_bad.read_not_write = 1'h0;
    lnk_bad.sync_address_bus = 6'h00;
    lnk_bad.dq_host_o = '0;
    lnk_bad.dq_host_oe = 1'h0;
    lnk_bad.width_cfg_strap = CFG_WIDE;
    lnk_bad.separate_io_mode_strap = 1'h1;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  task automatic check(input logic [W-1:0] seen, input logic [W-1:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Offer one request; valid stays up after the taking edge
  task automatic send(input logic w, input logic [AW-1:0] a, input logic [W-1:0] d);
    int n;
    n = 0;
    @(negedge core_clk);
    req_valid = 1'h1;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    // Ready is a register: its level at the fall holds at the rise
    while (req_ready !== 1'h1 && n < 300) begin
      @(negedge core_clk);
      n++;
    end
    @(posedge core_clk);
    if (n >= 300) check(1'h0, 1'h1);
    // Model updates at acceptance; order is preserved
    if (w) begin
      mem[int'(a)] = d;
      wq.push_back(d);
      cq.push_back(a);
    end else begin
      exp_q.push_back(mem[int'(a)]);
    end
  endtask
  task automatic drain();
    @(negedge core_clk);
    req_valid = 1'h0;
    for (int n = 0; n < 3000 && exp_q.size() != 0; n++) @(negedge core_clk);
    check(W'(exp_q.size()), '0);
  endtask
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Receiver stalls at random, or fully while stall is set
  always @(negedge core_clk) begin
    r = rnd();
    rsp_ready = !stall && (r[1:0] != 2'h0);
    // Every returned word against the model, taken at the coming rise
    if (rsp_valid === 1'h1 && rsp_ready === 1'h1) begin
      check(rsp_data, exp_q.pop_front());
    end
  end
  // Wire beats of a write: low half at rise, high half at fall
  always @(posedge lnk.ck) begin
    if (lnk.load_strobe_n === 1'h0 && lnk.read_not_write === RW_WRITE) begin
      check(W'(lnk.dq_bus), W'(wq[0][DW-1:0]));
      hi_due = 1'h1;
    end
  end
  always @(negedge lnk.ck) begin
    // Commit pulse stands from the rise; oldest write first
    if (commit_valid === 1'h1) check(W'(commit_addr), W'(cq.pop_front()));
    if (hi_due) begin
      check(W'(lnk.dq_bus), W'(wq[0][W-1:DW]));
      void'(wq.pop_front());
      hi_due = 1'h0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (12) @(negedge core_clk);
    rst_n = 1'h1;
    // Every word address distinct, back to back
    for (int i = 0; i < 64; i++) send(1'h1, AW'(i), W'({rnd(), rnd(), rnd()}));
    for (int i = 0; i < 64; i++) send(1'h0, AW'(i), '0);
    drain();
    // Random mix of reads and writes
    for (int i = 0; i < 300; i++) begin
      r = rnd();
      send(r[0], AW'(r[13:8]), W'({r, rnd(), rnd()}));
    end
    drain();
    // Fill the response buffer until requests are refused
    stall = 1'h1;
    repeat (3) send(1'h0, 6'h05, '0);
    repeat (40) @(negedge core_clk);
    check(req_ready, 1'h0);
    check(rsp_valid, 1'h1);
    stall = 1'h0;
    send(1'h0, 6'h05, '0);
    drain();
    check(cfg_error, 1'h0);
    check(cfg_error_bad, 1'h1);
    end_of_test();
  end
  // Watchdog
  initial begin
    #2_000_000;
    fails++;
    end_of_test();
  end
endmodule
`default_nettype wire
